/* File: verilog/bcte_pkg.sv */
`default_nettype none
package bcte_pkg;

    // ------------------------------------------------------------
    // cycle type codes
    // ------------------------------------------------------------
    localparam logic [3:0] CT_NORMAL = 4'h0;
    localparam logic [3:0] CT_RSV_OR_COF = 4'h1;
    localparam logic [3:0] CT_EMUL_MEM = 4'h2;
    localparam logic [3:0] CT_PORT_REPL = 4'h3;
    localparam logic [3:0] CT_VIS_IMEM = 4'h4;
    localparam logic [3:0] CT_VIS_LMEM = 4'h5;
    localparam logic [3:0] CT_VIS_EMEM_HIT = 4'h6;
    localparam logic [3:0] CT_VIS_CTRL_REG = 4'h7;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [3:0] CODE_RST = 4'h0;
    localparam int SYNC_STAGES = 2;
    localparam int VIS_ADDR_CYCLES = 1;
    localparam int VIS_DATA_CYCLES = 1;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BCTE_TGT_EXT_MEM,
        BCTE_TGT_EMUL_MEM,
        BCTE_TGT_PORT_REPL,
        BCTE_TGT_CTRL_REG,
        BCTE_TGT_INT_IMEM,
        BCTE_TGT_INT_LMEM
    } bcte_target_e;

    typedef enum logic [1:0] {
        BCTE_IDLE,
        BCTE_ADDR,
        BCTE_DATA
    } bcte_phase_e;

    // visibility cycles are the codes with bit 2 set
    function automatic logic bcte_self_term(input logic [3:0] code);
        bcte_self_term = code[2];
    endfunction : bcte_self_term

endpackage : bcte_pkg
`default_nettype wire

/* File: verilog/bcte_phase_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module bcte_phase_seq
    import bcte_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic start_in,
    input wire logic self_term_in,
    input wire logic has_data_in,
    input wire logic addr_ack_in,
    input wire logic transfer_ack_in,
    output logic idle_out,
    output logic addr_phase_out,
    output logic data_phase_out,
    output logic start_pulse_out,
    output logic done_out
);

    bcte_phase_e state;
    bcte_phase_e next_state;
    logic self_term;
    logic has_data;
    logic next_self_term;
    logic next_has_data;
    logic next_done;

    // ------------------------------------------------------------
    // phase sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_done = 1'b0;
        next_self_term = self_term;
        next_has_data = has_data;
        unique case (state)
            BCTE_IDLE:
            begin
                if (start_in)
                begin
                    next_state = BCTE_ADDR;
                    next_self_term = self_term_in;
                    next_has_data = has_data_in;
                end
            end
            BCTE_ADDR:
            begin
                if (self_term)
                begin
                    // one clock, no acknowledge awaited
                    next_state = has_data ? BCTE_DATA : BCTE_IDLE;
                    next_done = !has_data;
                end
                else if (addr_ack_in)
                begin
                    // ack pair may come together
                    next_state = transfer_ack_in ? BCTE_IDLE : BCTE_DATA;
                    next_done = transfer_ack_in;
                end
            end
            BCTE_DATA:
            begin
                if (self_term || transfer_ack_in)
                begin
                    next_state = BCTE_IDLE;
                    next_done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            state <= BCTE_IDLE;
            self_term <= 1'b0;
            has_data <= 1'b0;
            idle_out <= 1'b1;
            addr_phase_out <= 1'b0;
            data_phase_out <= 1'b0;
            start_pulse_out <= 1'b0;
            done_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            self_term <= next_self_term;
            has_data <= next_has_data;
            idle_out <= (next_state == BCTE_IDLE);
            addr_phase_out <= (next_state == BCTE_ADDR);
            data_phase_out <= (next_state == BCTE_DATA);
            start_pulse_out <= (state == BCTE_IDLE) && start_in;
            done_out <= next_done;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_vis_addr_one;
        @(posedge core_clk_in) disable iff (srst_in)
        addr_phase_out && self_term |=> !addr_phase_out;
    endproperty
    a_vis_addr_one: assert property (p_vis_addr_one)
        else $error("visibility address phase longer than one clock");

    property p_vis_data_one;
        @(posedge core_clk_in) disable iff (srst_in)
        addr_phase_out && self_term && has_data
            |=> data_phase_out ##1 !data_phase_out && done_out;
    endproperty
    a_vis_data_one: assert property (p_vis_data_one)
        else $error("visibility data phase not exactly one clock");

    property p_ext_waits_ack;
        @(posedge core_clk_in) disable iff (srst_in)
        addr_phase_out && !self_term && !addr_ack_in |=> addr_phase_out;
    endproperty
    a_ext_waits_ack: assert property (p_ext_waits_ack)
        else $error("external address phase ended without addr_ack");

    property p_ext_waits_tack;
        @(posedge core_clk_in) disable iff (srst_in)
        data_phase_out && !self_term && !transfer_ack_in
            |=> data_phase_out && !done_out;
    endproperty
    a_ext_waits_tack: assert property (p_ext_waits_tack)
        else $error("external data phase ended without transfer_ack");

endmodule : bcte_phase_seq
`default_nettype wire

/* File: verilog/bcte_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
module bcte_encoder
    import bcte_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic req_valid_in,
    input wire bcte_target_e req_target_in,
    input wire logic req_instr_in,
    input wire logic req_indirect_in,
    input wire logic req_reserve_in,
    input wire logic req_cache_hit_in,
    input wire logic req_aborted_in,
    input wire logic req_write_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic addr_ack_in,
    input wire logic transfer_ack_in,
    output logic req_ready_out,
    output logic [3:0] cycle_type_code_out,
    output logic transfer_start_out,
    output logic addr_phase_out,
    output logic data_phase_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic addr_type_instr_bit_out,
    output logic write_read_ind_out,
    output logic self_term_out,
    output logic cycle_done_out
);

    // ------------------------------------------------------------
    // classification
    // ------------------------------------------------------------
    function automatic logic [3:0] encode_cycle(
        input bcte_target_e target,
        input logic instr,
        input logic indirect,
        input logic reserve,
        input logic hit,
        input logic aborted
    );
        logic [3:0] code;
        code = CT_NORMAL;
        unique case (target)
            BCTE_TGT_CTRL_REG:
                code = CT_VIS_CTRL_REG;
            BCTE_TGT_INT_IMEM:
                code = CT_VIS_IMEM;
            BCTE_TGT_INT_LMEM:
                code = CT_VIS_LMEM;
            BCTE_TGT_PORT_REPL:
                code = CT_PORT_REPL;
            BCTE_TGT_EMUL_MEM:
            begin
                // a hit in the cache is echoed as internal visibility
                if (hit)
                    code = instr ? CT_VIS_IMEM : CT_VIS_LMEM;
                else
                    code = CT_EMUL_MEM;
            end
            BCTE_TGT_EXT_MEM:
            begin
                if (hit || (instr && aborted))
                    code = CT_VIS_EMEM_HIT;
                else if (instr && indirect)
                    code = CT_RSV_OR_COF;
                else if (!instr && reserve)
                    code = CT_RSV_OR_COF;
                else
                    code = CT_NORMAL;
            end
            default:
                code = CT_NORMAL;
        endcase
        encode_cycle = code;
    endfunction : encode_cycle

    // instruction bus echoes are address only; register access always
    // carries data
    function automatic logic cycle_has_data(
        input logic [3:0] code,
        input logic instr
    );
        if (code == CT_VIS_CTRL_REG)
            cycle_has_data = 1'b1;
        else if (bcte_self_term(code))
            cycle_has_data = !instr;
        else
            cycle_has_data = 1'b1;
    endfunction : cycle_has_data

    // indirect branch targets are flagged by a write on the r/w line on emulation memory and visibility cycles; external 0001 fetches read
    function automatic logic cycle_wr(
        input logic [3:0] code,
        input logic instr,
        input logic indirect,
        input logic write
    );
        if (!instr)
            cycle_wr = write;
        else if (code == CT_EMUL_MEM)
            cycle_wr = indirect;
        else if (bcte_self_term(code))
            cycle_wr = indirect;
        else
            cycle_wr = 1'b0;
    endfunction : cycle_wr

    // ------------------------------------------------------------
    // acknowledge synchronisers
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] addr_ack_sync;
    logic [SYNC_STAGES-1:0] tack_sync;
    logic [SYNC_STAGES-1:0] next_addr_ack_sync;
    logic [SYNC_STAGES-1:0] next_tack_sync;

    always_comb
    begin
        next_addr_ack_sync = {addr_ack_sync[SYNC_STAGES-2:0], addr_ack_in};
        next_tack_sync = {tack_sync[SYNC_STAGES-2:0], transfer_ack_in};
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            addr_ack_sync <= '0;
            tack_sync <= '0;
        end
        else
        begin
            addr_ack_sync <= next_addr_ack_sync;
            tack_sync <= next_tack_sync;
        end
    end

    // ------------------------------------------------------------
    // request capture
    // ------------------------------------------------------------
    logic take;
    logic [3:0] req_code;
    logic req_has_data;
    logic req_wr;
    logic [3:0] next_code;
    logic [ADDR_W-1:0] next_addr;
    logic next_instr_bit;
    logic next_wr;
    logic next_self_term;

    always_comb
    begin
        take = req_valid_in && req_ready_out;
        req_code = encode_cycle(req_target_in, req_instr_in,
            req_indirect_in, req_reserve_in, req_cache_hit_in,
            req_aborted_in);
        req_has_data = cycle_has_data(req_code, req_instr_in);
        req_wr = cycle_wr(req_code, req_instr_in, req_indirect_in,
            req_write_in);
        // held until the next request so an observer sees it with the
        // address for the whole phase
        next_code = cycle_type_code_out;
        next_addr = addr_out;
        next_instr_bit = addr_type_instr_bit_out;
        next_wr = write_read_ind_out;
        next_self_term = self_term_out;
        if (take)
        begin
            next_code = req_code;
            next_addr = req_addr_in;
            next_instr_bit = req_instr_in;
            next_wr = req_wr;
            next_self_term = bcte_self_term(req_code);
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            cycle_type_code_out <= CODE_RST;
            addr_out <= '0;
            addr_type_instr_bit_out <= 1'b0;
            write_read_ind_out <= 1'b0;
            self_term_out <= 1'b0;
        end
        else
        begin
            cycle_type_code_out <= next_code;
            addr_out <= next_addr;
            addr_type_instr_bit_out <= next_instr_bit;
            write_read_ind_out <= next_wr;
            self_term_out <= next_self_term;
        end
    end

    // ------------------------------------------------------------
    // phase sequencer
    // ------------------------------------------------------------
    bcte_phase_seq u_seq (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .start_in(take),
        .self_term_in(bcte_self_term(req_code)),
        .has_data_in(req_has_data),
        .addr_ack_in(addr_ack_sync[SYNC_STAGES-1]),
        .transfer_ack_in(tack_sync[SYNC_STAGES-1]),
        .idle_out(req_ready_out),
        .addr_phase_out(addr_phase_out),
        .data_phase_out(data_phase_out),
        .start_pulse_out(transfer_start_out),
        .done_out(cycle_done_out)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_ts_opens_phase;
        @(posedge core_clk_in) disable iff (srst_in)
        take |=> transfer_start_out && addr_phase_out ##1 !transfer_start_out;
    endproperty
    a_ts_opens_phase: assert property (p_ts_opens_phase)
        else $error("transfer start not a single clock at phase start");

    property p_code_normal;
        @(posedge core_clk_in) disable iff (srst_in)
        take && req_target_in == BCTE_TGT_EXT_MEM && !req_cache_hit_in
            && !req_instr_in && !req_reserve_in
            |=> cycle_type_code_out == CT_NORMAL && !self_term_out;
    endproperty
    a_code_normal: assert property (p_code_normal)
        else $error("plain external data access not coded normal");

    property p_code_rsv;
        @(posedge core_clk_in) disable iff (srst_in)
        take && req_target_in == BCTE_TGT_EXT_MEM && !req_cache_hit_in
            && !req_instr_in && req_reserve_in
            |=> cycle_type_code_out == CT_RSV_OR_COF
            && !addr_type_instr_bit_out;
    endproperty
    a_code_rsv: assert property (p_code_rsv)
        else $error("reservation start not coded 0001");

    property p_code_cof;
        @(posedge core_clk_in) disable iff (srst_in)
        take && req_target_in == BCTE_TGT_EXT_MEM && !req_cache_hit_in
            && !req_aborted_in && req_instr_in && req_indirect_in
            |=> cycle_type_code_out == CT_RSV_OR_COF
            && addr_type_instr_bit_out;
    endproperty
    a_code_cof: assert property (p_code_cof)
        else $error("indirect fetch not coded 0001");

    property p_code_emul;
        @(posedge core_clk_in) disable iff (srst_in)
        take && req_target_in == BCTE_TGT_EMUL_MEM && !req_cache_hit_in
            |=> cycle_type_code_out == CT_EMUL_MEM
            && write_read_ind_out == ($past(req_instr_in)
            ? $past(req_indirect_in) : $past(req_write_in));
    endproperty
    a_code_emul: assert property (p_code_emul)
        else $error("emulation memory code or r/w flag wrong");

    property p_code_port;
        @(posedge core_clk_in) disable iff (srst_in)
        take && req_target_in == BCTE_TGT_PORT_REPL
            |=> cycle_type_code_out == CT_PORT_REPL;
    endproperty
    a_code_port: assert property (p_code_port)
        else $error("port replacement access not coded 0011");

    property p_vis_wr;
        @(posedge core_clk_in) disable iff (srst_in)
        take && (req_target_in == BCTE_TGT_INT_IMEM
            || req_target_in == BCTE_TGT_INT_LMEM) && req_instr_in
            |=> self_term_out && write_read_ind_out == $past(req_indirect_in);
    endproperty
    a_vis_wr: assert property (p_vis_wr)
        else $error("internal visibility indirect flag wrong");

    property p_emem_hit;
        @(posedge core_clk_in) disable iff (srst_in)
        take && req_target_in == BCTE_TGT_EXT_MEM && req_cache_hit_in
            && req_instr_in && req_indirect_in
            |=> cycle_type_code_out == CT_VIS_EMEM_HIT && write_read_ind_out
            ##1 !addr_phase_out && !data_phase_out;
    endproperty
    a_emem_hit: assert property (p_emem_hit)
        else $error("cache hit echo wrong code, flag or length");

    property p_ctrl_reg;
        @(posedge core_clk_in) disable iff (srst_in)
        take && req_target_in == BCTE_TGT_CTRL_REG
            |=> cycle_type_code_out == CT_VIS_CTRL_REG && addr_phase_out
            ##1 data_phase_out ##1 cycle_done_out;
    endproperty
    a_ctrl_reg: assert property (p_ctrl_reg)
        else $error("register access echo not address then data");

    property p_addr_stable;
        @(posedge core_clk_in) disable iff (srst_in)
        addr_phase_out && $past(addr_phase_out)
            |-> $stable(cycle_type_code_out) && $stable(addr_out)
            && !transfer_start_out;
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("code or address moved within address phase");

endmodule : bcte_encoder
`default_nettype wire

/* File: sim/bcte_ext_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module bcte_ext_partner
(
    input wire logic core_clk_in,
    input wire logic transfer_start_in,
    input wire logic self_term_in,
    input wire logic data_phase_in,
    input wire logic [3:0] cycle_type_code_in,
    input wire logic addr_type_instr_bit_in,
    input wire logic [31:0] addr_in,
    input wire logic [3:0] delay_in,
    input wire logic joint_in,
    output logic addr_ack_out,
    output logic transfer_ack_out,
    output logic [31:0] snoop_addr_out
);
    // ------------------------------------------------------------
    // acknowledge responder
    // ------------------------------------------------------------
    // no dma master lives here, so emulation memory is never shared
    initial
    begin
        int k;
        addr_ack_out = 1'b0;
        transfer_ack_out = 1'b0;
        forever
        begin
            @(posedge core_clk_in);
            // visibility cycles get no acks at all
            if (transfer_start_in === 1'b1 && self_term_in === 1'b0)
            begin
                repeat (delay_in) @(posedge core_clk_in);
                addr_ack_out <= 1'b1;
                transfer_ack_out <= joint_in;
                @(posedge core_clk_in);
                addr_ack_out <= 1'b0;
                transfer_ack_out <= 1'b0;
                k = 0;
                while (joint_in === 1'b0 && data_phase_in !== 1'b1 && k < 20)
                begin
                    k++;
                    @(posedge core_clk_in);
                end
                if (joint_in === 1'b0)
                begin
                    repeat (delay_in) @(posedge core_clk_in);
                    transfer_ack_out <= 1'b1;
                    @(posedge core_clk_in);
                    transfer_ack_out <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // reservation snoop
    // ------------------------------------------------------------
    initial
    begin
        snoop_addr_out = 32'h0000_0000;
        forever
        begin
            @(posedge core_clk_in);
            if (transfer_start_in === 1'b1 && cycle_type_code_in === 4'h1
                && addr_type_instr_bit_in === 1'b0)
                snoop_addr_out <= addr_in;
        end
    end
endmodule : bcte_ext_partner
`default_nettype wire

/* File: sim/bcte_encoder_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("mismatch %0t %s", $time, msg); \
        end \
    end
module bcte_encoder_bench;
    import bcte_pkg::*;

    logic clk, srst, req_valid, req_instr, req_indirect, req_reserve;
    logic req_cache_hit, req_aborted, req_write, addr_ack, transfer_ack;
    bcte_target_e req_target;
    logic [31:0] req_addr, addr, snoop_addr, last_addr;
    logic req_ready, ts, addr_phase, data_phase, instr_bit, wr, self_term;
    logic cycle_done, joint;
    logic [3:0] code, delay;
    int n_mismatch = 0;
    int num_checks = 0;

    bcte_encoder #(.ADDR_W(32)) dut (
        .core_clk_in(clk), .srst_in(srst), .req_valid_in(req_valid),
        .req_target_in(req_target), .req_instr_in(req_instr),
        .req_indirect_in(req_indirect), .req_reserve_in(req_reserve),
        .req_cache_hit_in(req_cache_hit), .req_aborted_in(req_aborted),
        .req_write_in(req_write), .req_addr_in(req_addr),
        .addr_ack_in(addr_ack), .transfer_ack_in(transfer_ack),
        .req_ready_out(req_ready), .cycle_type_code_out(code),
        .transfer_start_out(ts), .addr_phase_out(addr_phase),
        .data_phase_out(data_phase), .addr_out(addr),
        .addr_type_instr_bit_out(instr_bit), .write_read_ind_out(wr),
        .self_term_out(self_term), .cycle_done_out(cycle_done));

    bcte_ext_partner far (
        .core_clk_in(clk), .transfer_start_in(ts), .self_term_in(self_term),
        .data_phase_in(data_phase), .cycle_type_code_in(code),
        .addr_type_instr_bit_in(instr_bit), .addr_in(addr),
        .delay_in(delay), .joint_in(joint), .addr_ack_out(addr_ack),
        .transfer_ack_out(transfer_ack), .snoop_addr_out(snoop_addr));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic close_out();
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    task automatic hang();
        n_mismatch++;
        $display("mismatch %0t wait ran out", $time);
        close_out();
    endtask : hang

    // attr is {instr, indirect, reserve, hit, aborted, write}
    task automatic do_cycle(input bcte_target_e t, input logic [5:0] attr,
        input logic [3:0] exp_code, input logic exp_wr,
        input logic exp_data);
        int n;
        logic saw_data;
        last_addr = last_addr + 32'h0000_0104;
        @(posedge clk);
        req_valid <= 1'b1;
        req_target <= t;
        {req_instr, req_indirect, req_reserve} <= attr[5:3];
        {req_cache_hit, req_aborted, req_write} <= attr[2:0];
        req_addr <= last_addr;
        n = 0;
        @(negedge clk);
        while (req_ready !== 1'b1)
        begin
            if (++n > 50)
                hang();
            @(negedge clk);
        end
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
        `CHK(ts, 1'b1, "no start pulse")
        `CHK(req_ready, 1'b0, "ready during cycle")
        `CHK(instr_bit, attr[5], "address type")
        `CHK(wr, exp_wr, "write indication")
        `CHK(self_term, exp_code[2], "self termination")
        n = 0;
        saw_data = 1'b0;
        while (cycle_done !== 1'b1)
        begin
            if (addr_phase === 1'b1)
            begin
                `CHK(code, exp_code, "code in address phase")
                `CHK(addr, last_addr, "address in phase")
            end
            if (n > 0)
                `CHK(ts, 1'b0, "start pulse too long")
            if (data_phase === 1'b1)
                saw_data = 1'b1;
            if (++n > 60)
                hang();
            @(negedge clk);
        end
        `CHK(saw_data, exp_data, "data phase presence")
        `CHK(req_ready, 1'b1, "ready at done")
        if (exp_code[2] === 1'b1)
            `CHK(n, exp_data ? 2 : 1, "visibility length")
    endtask : do_cycle

    task automatic test_reset();
        `CHK(req_ready, 1'b1, "ready after reset")
        `CHK(code, CODE_RST, "code after reset")
        `CHK(addr, 32'h0000_0000, "address after reset")
        `CHK(ts, 1'b0, "start after reset")
    endtask : test_reset

    task automatic test_external();
        delay <= 4'h0;
        do_cycle(BCTE_TGT_EXT_MEM, 6'h00, CT_NORMAL,
            1'b0, 1'b1);
        delay <= 4'h3;
        do_cycle(BCTE_TGT_EXT_MEM, 6'h09, CT_RSV_OR_COF,
            1'b1, 1'b1);
        `CHK(snoop_addr, last_addr, "reservation address")
        do_cycle(BCTE_TGT_EXT_MEM, 6'h30, CT_RSV_OR_COF,
            1'b0, 1'b1);
        do_cycle(BCTE_TGT_EMUL_MEM, 6'h30, CT_EMUL_MEM,
            1'b1, 1'b1);
        // both acks together end the cycle without a data phase
        joint <= 1'b1;
        do_cycle(BCTE_TGT_PORT_REPL, 6'h01, CT_PORT_REPL,
            1'b1, 1'b0);
        joint <= 1'b0;
    endtask : test_external

    task automatic test_visibility();
        do_cycle(BCTE_TGT_INT_IMEM, 6'h30, CT_VIS_IMEM,
            1'b1, 1'b0);
        do_cycle(BCTE_TGT_INT_IMEM, 6'h20, CT_VIS_IMEM,
            1'b0, 1'b0);
        do_cycle(BCTE_TGT_INT_LMEM, 6'h01, CT_VIS_LMEM,
            1'b1, 1'b1);
        do_cycle(BCTE_TGT_EMUL_MEM, 6'h04, CT_VIS_LMEM,
            1'b0, 1'b1);
        do_cycle(BCTE_TGT_EXT_MEM, 6'h34, CT_VIS_EMEM_HIT,
            1'b1, 1'b0);
        do_cycle(BCTE_TGT_EXT_MEM, 6'h22, CT_VIS_EMEM_HIT,
            1'b0, 1'b0);
        do_cycle(BCTE_TGT_EXT_MEM, 6'h05, CT_VIS_EMEM_HIT,
            1'b1, 1'b1);
        do_cycle(BCTE_TGT_CTRL_REG, 6'h20, CT_VIS_CTRL_REG,
            1'b0, 1'b1);
        do_cycle(BCTE_TGT_CTRL_REG, 6'h04, CT_VIS_CTRL_REG,
            1'b0, 1'b1);
    endtask : test_visibility

    initial
    begin
        srst = 1'b1;
        req_valid = 1'b0;
        req_target = BCTE_TGT_EXT_MEM;
        {req_instr, req_indirect, req_reserve} = 3'h0;
        {req_cache_hit, req_aborted, req_write} = 3'h0;
        req_addr = 32'h0000_0000;
        last_addr = 32'h0000_1000;
        delay = 4'h0;
        joint = 1'b0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        test_reset();
        test_external();
        test_visibility();
        close_out();
    end
endmodule : bcte_encoder_bench
`default_nettype wire
